// File: logic/lsm_map.svh
// register offsets, field positions, reset values and sizes of the segment memory block
`ifndef LSM_MAP_SVH
`define LSM_MAP_SVH

`define LSM_OFS_MAIN_CONFIG 8'h95
`define LSM_OFS_CLOCK_SELECT 8'h96
`define LSM_OFS_VOLTAGE_CONFIG 8'h9c
`define LSM_OFS_MEM_POINTER 8'hac
`define LSM_OFS_MEM_DATA 8'hae
`define LSM_OFS_UPDATE_CONTROL 8'hb1

`define LSM_MAIN_DISPLAY_ENABLE_BIT 7
`define LSM_MAIN_MEM_CLEAR_BIT 6
`define LSM_MAIN_LOWPOWER_OFF_BIT 5
`define LSM_CLK_BLINK_MODE_HI 7
`define LSM_CLK_BLINK_MODE_LO 6
`define LSM_CLK_BLINK_FREQ_HI 5
`define LSM_CLK_BLINK_FREQ_LO 4
`define LSM_VOLT_LADDER_BIT 6
`define LSM_VOLT_BIAS_HI 5
`define LSM_VOLT_BIAS_LO 0
`define LSM_PTR_WRITE_BIT 7
`define LSM_PTR_ADDR_HI 5
`define LSM_PTR_ADDR_LO 0
`define LSM_UPD_FREEZE_BIT 0

`define LSM_RST_BYTE 8'h00
`define LSM_PTR_WMASK 8'hbf
`define LSM_MAIN_WMASK 8'hbf
`define LSM_MEM_DEPTH 15
`define LSM_MEM_LAST 6'h0e
`define LSM_LAST_BYTE_MASK 8'h0f
`define LSM_BLINK_AUTO_MODE 2'b10
`define LSM_BLINK_FIXED_MODE 2'b11
`define LSM_BLINK_FIFTH_RATE 3'h4

`endif

// File: logic/lsm_pkg.sv
// state types of the segment memory block
`include "lsm_map.svh"
package lsm_pkg;
    typedef logic [7:0] lsm_byte_t;
    typedef logic [`LSM_MEM_DEPTH-1:0][7:0] lsm_bank_t;

    // all state of the memory bank
    typedef struct packed {
        lsm_bank_t mem;   // live segment bytes
        lsm_bank_t image; // bytes shown on the glass
    } lsm_bank_s;

    // all state of the register front end
    typedef struct packed {
        lsm_byte_t main_cfg;   // main configuration
        lsm_byte_t clk_sel;    // clock and blink selection
        lsm_byte_t volt_cfg;   // voltage source and bias
        lsm_byte_t ptr;        // memory pointer
        lsm_byte_t data;       // memory data
        lsm_byte_t upd_ctrl;   // update control
        lsm_byte_t rdata;      // read data to processor
        logic display_on;      // display driven
        logic pump_on;         // charge pump running
        logic ladder_on;       // external ladder in use
        logic comp_en;         // bias compensation allowed
        logic [5:0] bias;      // bias level to pump
        logic auto_blink;      // automatic blink active
        logic [2:0] blink_rate; // automatic blink rate index
    } lsm_top_s;
endpackage

// File: logic/lsm_bank.sv
// segment memory bank with frozen display image
`timescale 1ns/100ps
`include "lsm_map.svh"
module lsm_bank (
    input wire logic clk_sys, // system clock
    input wire logic reset, // sync reset, active high
    input wire logic clk_en, // freezes state when low
    input wire logic wr_en, // write pulse
    input wire logic [5:0] wr_addr, // write address
    input wire logic [7:0] wr_data, // write byte
    input wire logic clr, // clear all bytes
    input wire logic freeze, // hold displayed image
    input wire logic [5:0] rd_addr, // read address
    output logic [7:0] rd_data, // read byte, zero out of range
    output logic [8*`LSM_MEM_DEPTH-1:0] image // displayed bytes
);
    lsm_pkg::lsm_bank_s st_ff;
    lsm_pkg::lsm_bank_s nxt_st;
    lsm_pkg::lsm_bank_t nxt_mem; // per-entry next bytes

    // one update path per memory byte
    genvar gi;
    generate
        for (gi = 0; gi < `LSM_MEM_DEPTH; gi++) begin : g_entry // RULE_02
            localparam logic [5:0] IDX = 6'(gi);
            localparam logic [7:0] KEEP = (gi == `LSM_MEM_DEPTH - 1) ? `LSM_LAST_BYTE_MASK : 8'hff;
            always_comb begin
                if (clr) begin
                    nxt_mem[gi] = `LSM_RST_BYTE; // RULE_15
                end else if (wr_en && wr_addr == IDX) begin
                    nxt_mem[gi] = wr_data & KEEP; // RULE_06 RULE_03
                end else begin
                    nxt_mem[gi] = st_ff.mem[gi]; // RULE_04
                end
            end
        end
    endgenerate

    // image follows memory unless frozen
    always_comb begin
        nxt_st = st_ff;
        nxt_st.mem = nxt_mem;
        if (!freeze) begin
            nxt_st.image = st_ff.mem; // RULE_08
        end
    end

    // state register, cleared at reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_ff <= '0; // RULE_15
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    // read port, out of range reads zero
    always_comb begin
        if (rd_addr <= `LSM_MEM_LAST) begin
            rd_data = st_ff.mem[rd_addr[3:0]]; // RULE_07
        end else begin
            rd_data = `LSM_RST_BYTE; // RULE_17
        end
    end

    assign image = st_ff.image;
endmodule

// File: logic/lsm_top.sv
// register front end and display gating of the segment memory block
//
// What this block does
// RULE_01: five auto blink rates when clock running
// RULE_02: fifteen segment bytes, addresses zero to fourteen
// RULE_03: low nibble even segment, high odd
// RULE_04: memory kept during battery sleep
// RULE_05: pointer write starts read or write transfer
// RULE_06: pointer top bit set writes data byte
// RULE_07: pointer top bit clear loads data byte
// RULE_08: update bit holds previous displayed image
// RULE_09: software loads data before pointer write
// RULE_10: ladder select bit, clear means pump
// RULE_11: ladder selected disables bias compensation
// RULE_12: pump stops when display disabled
// RULE_13: six bit bias level, 64 steps
// RULE_14: sleep display needs enable, not off bit
// RULE_15: clear bit or reset zeroes memory
// RULE_16: pointer bit7 direction, bit6 reserved, address
// RULE_17: out of range: no write, reads zero
// RULE_18: read data ready next instruction
`timescale 1ns/100ps
`include "lsm_map.svh"
module lsm_top (
    input wire logic clk_sys, // system clock, 200 MHz
    input wire logic reset, // sync reset, active high
    input wire logic clk_en, // freezes all state when low
    input wire logic [7:0] sfr_addr, // register address
    input wire logic sfr_wr, // register write strobe
    input wire logic [7:0] sfr_wdata, // register write data
    input wire logic rtc_enabled, // real-time clock running
    input wire logic battery_sleep_state, // low-power mode active
    output logic [7:0] sfr_rdata, // registered read data
    output logic [8*`LSM_MEM_DEPTH-1:0] segment_image, // displayed bytes
    output logic display_on, // display driven
    output logic pump_on, // charge pump enable
    output logic ladder_on, // external ladder in use
    output logic comp_en, // bias compensation allowed
    output logic [5:0] bias_level, // bias level to pump
    output logic auto_blink, // automatic blink active
    output logic [2:0] blink_rate // automatic blink rate index
);
    lsm_pkg::lsm_top_s st_ff;
    lsm_pkg::lsm_top_s nxt_st;
    logic ptr_wr; // pointer written this cycle
    logic main_wr; // main config written this cycle
    logic mem_wr; // memory write transfer
    logic mem_clr; // memory clear pulse
    logic [5:0] bank_rd_addr; // bank read address
    logic [7:0] bank_rd; // bank read byte
    logic [1:0] blink_mode_field; // blink mode
    logic [1:0] blink_frequency_field; // blink frequency
    logic external_ladder_select; // ladder chosen
    logic display_enable_bit; // display enable
    logic lowpower_display_off; // off in sleep

    // decode of the register strobes
    always_comb begin
        ptr_wr = sfr_wr && sfr_addr == `LSM_OFS_MEM_POINTER; // RULE_05
        main_wr = sfr_wr && sfr_addr == `LSM_OFS_MAIN_CONFIG;
        mem_wr = ptr_wr && sfr_wdata[`LSM_PTR_WRITE_BIT]; // RULE_06 RULE_09
        mem_clr = main_wr && sfr_wdata[`LSM_MAIN_MEM_CLEAR_BIT]; // RULE_15
        // a new pointer is looked up at once so the read lands this edge
        bank_rd_addr = ptr_wr ? sfr_wdata[`LSM_PTR_ADDR_HI:`LSM_PTR_ADDR_LO] :
            st_ff.ptr[`LSM_PTR_ADDR_HI:`LSM_PTR_ADDR_LO]; // RULE_16 RULE_18
    end

    // field views of the stored registers
    always_comb begin
        blink_mode_field = st_ff.clk_sel[`LSM_CLK_BLINK_MODE_HI:`LSM_CLK_BLINK_MODE_LO];
        blink_frequency_field = st_ff.clk_sel[`LSM_CLK_BLINK_FREQ_HI:`LSM_CLK_BLINK_FREQ_LO];
        external_ladder_select = st_ff.volt_cfg[`LSM_VOLT_LADDER_BIT]; // RULE_10
        display_enable_bit = st_ff.main_cfg[`LSM_MAIN_DISPLAY_ENABLE_BIT];
        lowpower_display_off = st_ff.main_cfg[`LSM_MAIN_LOWPOWER_OFF_BIT];
    end

    // segment memory, freeze and clear
    lsm_bank u_bank (
        .clk_sys(clk_sys),
        .reset(reset),
        .clk_en(clk_en),
        .wr_en(mem_wr),
        .wr_addr(sfr_wdata[`LSM_PTR_ADDR_HI:`LSM_PTR_ADDR_LO]),
        .wr_data(st_ff.data),
        .clr(mem_clr),
        .freeze(st_ff.upd_ctrl[`LSM_UPD_FREEZE_BIT]),
        .rd_addr(bank_rd_addr),
        .rd_data(bank_rd),
        .image(segment_image)
    );

    // next state of registers and derived outputs
    always_comb begin
        nxt_st = st_ff;
        // register writes
        if (sfr_wr) begin
            case (sfr_addr)
                `LSM_OFS_MAIN_CONFIG: nxt_st.main_cfg = sfr_wdata & `LSM_MAIN_WMASK; // clear bit self-clears
                `LSM_OFS_CLOCK_SELECT: nxt_st.clk_sel = sfr_wdata;
                `LSM_OFS_VOLTAGE_CONFIG: nxt_st.volt_cfg = sfr_wdata; // RULE_10 RULE_13
                `LSM_OFS_MEM_POINTER: nxt_st.ptr = sfr_wdata & `LSM_PTR_WMASK; // RULE_16
                `LSM_OFS_MEM_DATA: nxt_st.data = sfr_wdata;
                `LSM_OFS_UPDATE_CONTROL: nxt_st.upd_ctrl = sfr_wdata; // RULE_08
                default: nxt_st = st_ff; // unmapped: ignored
            endcase
        end
        // read transfer loads the data register
        if (ptr_wr && !sfr_wdata[`LSM_PTR_WRITE_BIT]) begin
            nxt_st.data = bank_rd; // RULE_07 RULE_17 RULE_18
        end
        // read data, registered
        case (sfr_addr)
            `LSM_OFS_MAIN_CONFIG: nxt_st.rdata = st_ff.main_cfg;
            `LSM_OFS_CLOCK_SELECT: nxt_st.rdata = st_ff.clk_sel;
            `LSM_OFS_VOLTAGE_CONFIG: nxt_st.rdata = st_ff.volt_cfg;
            `LSM_OFS_MEM_POINTER: nxt_st.rdata = st_ff.ptr;
            `LSM_OFS_MEM_DATA: nxt_st.rdata = st_ff.data;
            `LSM_OFS_UPDATE_CONTROL: nxt_st.rdata = st_ff.upd_ctrl;
            default: nxt_st.rdata = `LSM_RST_BYTE; // unmapped reads zero
        endcase
        // display gating, sleep needs enable and no off bit
        if (battery_sleep_state) begin
            nxt_st.display_on = display_enable_bit && !lowpower_display_off; // RULE_14
        end else begin
            nxt_st.display_on = display_enable_bit;
        end
        // voltage source
        nxt_st.ladder_on = external_ladder_select; // RULE_10
        nxt_st.pump_on = nxt_st.display_on && !external_ladder_select; // RULE_12
        nxt_st.comp_en = !external_ladder_select; // RULE_11
        nxt_st.bias = st_ff.volt_cfg[`LSM_VOLT_BIAS_HI:`LSM_VOLT_BIAS_LO]; // RULE_13
        // automatic blink: four rates in one mode, a fifth in the other
        if (rtc_enabled && blink_mode_field == `LSM_BLINK_AUTO_MODE) begin
            nxt_st.auto_blink = 1'b1; // RULE_01
            nxt_st.blink_rate = {1'b0, blink_frequency_field};
        end else if (rtc_enabled && blink_mode_field == `LSM_BLINK_FIXED_MODE) begin
            nxt_st.auto_blink = 1'b1; // RULE_01
            nxt_st.blink_rate = `LSM_BLINK_FIFTH_RATE;
        end else begin
            nxt_st.auto_blink = 1'b0;
            nxt_st.blink_rate = 3'h0;
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_ff <= '0;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from flops
    assign sfr_rdata = st_ff.rdata;
    assign display_on = st_ff.display_on;
    assign pump_on = st_ff.pump_on;
    assign ladder_on = st_ff.ladder_on;
    assign comp_en = st_ff.comp_en;
    assign bias_level = st_ff.bias;
    assign auto_blink = st_ff.auto_blink;
    assign blink_rate = st_ff.blink_rate;

    // checks, all on the system clock and idle during reset
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    // read transfer loads the addressed byte
    rd_load_data_a: assert property (clk_en && ptr_wr && !sfr_wdata[7] && sfr_wdata[5:0] <= 6'h0e // RULE_07
        |=> st_ff.data == $past(bank_rd)) else $error("read transfer did not load data");
    // write transfer lands in the addressed byte
    wr_store_mem_a: assert property (clk_en && mem_wr && sfr_wdata[5:0] < 6'h0e ##1 !ptr_wr // RULE_06
        |-> bank_rd == $past(st_ff.data)) else $error("write transfer did not store byte");
    // out of range read gives zero
    out_range_a: assert property (clk_en && ptr_wr && !sfr_wdata[7] && sfr_wdata[5:0] > 6'h0e // RULE_17
        |=> st_ff.data == 8'h00) else $error("out of range read not zero");
    // clear bit empties the bank at once
    clear_mem_a: assert property (clk_en && mem_clr ##1 !ptr_wr |-> bank_rd == 8'h00) // RULE_15
        else $error("memory clear failed");
    // frozen image does not move
    freeze_hold_a: assert property (clk_en && st_ff.upd_ctrl[0] |=> $stable(segment_image)) // RULE_08
        else $error("image changed while frozen");

    // off bit in sleep darkens the glass and stops the pump
    sleep_off_a: assert property (clk_en && battery_sleep_state && lowpower_display_off // RULE_14
        |=> !display_on && !pump_on) else $error("display on in sleep with off bit");
    // enable without off bit keeps the glass lit in sleep
    sleep_on_a: assert property (clk_en && battery_sleep_state && display_enable_bit // RULE_14
        && !lowpower_display_off |=> display_on) else $error("display off in sleep with enable");
    // pump only runs for a lit display on its own source
    pump_gate_a: assert property (pump_on |-> display_on && !ladder_on) // RULE_12
        else $error("pump on without display or with ladder");
    // ladder chosen: no compensation
    ladder_comp_a: assert property (clk_en && external_ladder_select |=> ladder_on && !comp_en) // RULE_11
        else $error("compensation active with ladder");
    // select bit clear: pump source, compensation allowed
    pump_select_a: assert property (clk_en && !external_ladder_select |=> !ladder_on && comp_en) // RULE_10
        else $error("pump source not chosen with select bit clear");
    // bias output follows the register field
    bias_follow_a: assert property (clk_en |=> bias_level == $past(st_ff.volt_cfg[5:0])) // RULE_13
        else $error("bias level not following register");

    // automatic blink only with the clock running
    blink_rate_a: assert property (auto_blink |-> blink_rate <= 3'h4 && $past(rtc_enabled)) // RULE_01
        else $error("blink rate out of range");
    // fixed blink mode picks the fifth rate
    blink_fifth_a: assert property (clk_en && rtc_enabled && blink_mode_field == `LSM_BLINK_FIXED_MODE // RULE_01
        |=> auto_blink && blink_rate == `LSM_BLINK_FIFTH_RATE) else $error("fifth blink rate not chosen");
    // reserved pointer bit never stored
    ptr_reserved_a: assert property (!st_ff.ptr[6]) // RULE_16
        else $error("reserved pointer bit set");
    // data register readable right after a transfer
    data_visible_a: assert property (clk_en && sfr_addr == `LSM_OFS_MEM_DATA |=> sfr_rdata == $past(st_ff.data)) // RULE_18
        else $error("data register not readable");
    // low clock enable holds every register
    hold_state_a: assert property (!clk_en |=> $stable(st_ff)) // clock enable hold
        else $error("state moved with clock enable low");

    // main scenarios reached
    wr_seen_c: cover property (clk_en && mem_wr ##1 clk_en && ptr_wr && !sfr_wdata[7]);
    freeze_seen_c: cover property (st_ff.upd_ctrl[0] && mem_wr ##[1:20] !st_ff.upd_ctrl[0]);
    sleep_seen_c: cover property (battery_sleep_state && display_on);
    clear_seen_c: cover property (clk_en && mem_clr);
    range_seen_c: cover property (clk_en && ptr_wr && sfr_wdata[5:0] > 6'h0e);
endmodule

// File: verification/lsm_glass.sv
// glass panel model: maps displayed bytes onto segment and common lines
`timescale 1ns/100ps
`include "lsm_map.svh"
module lsm_glass (
    input wire logic [8*`LSM_MEM_DEPTH-1:0] segment_image, // bytes from the block
    input wire logic display_on, // panel driven
    output logic [28:0][3:0] seg_lit // lit state, one nibble of commons per segment line
);
    // even line from low nibble, odd from high; dark when not driven
    always_comb begin
        for (int n = 0; n < 29; n++) begin
            seg_lit[n] = display_on ? segment_image[8*(n/2)+4*(n%2) +: 4] : 4'h0;
        end
    end
endmodule

// File: verification/tb_lcd_segment_memory_ctrl.sv
// self-checking bench for the segment memory block
`timescale 1ns/100ps
`include "lsm_map.svh"
module tb_lcd_segment_memory_ctrl;
    logic clk_sys; // system clock
    logic reset; // sync reset
    logic clk_en; // clock enable
    logic [7:0] sfr_addr; // register address
    logic sfr_wr; // write strobe
    logic [7:0] sfr_wdata; // write data
    logic rtc_enabled; // clock running
    logic battery_sleep_state; // low-power mode
    logic [7:0] sfr_rdata; // read data
    logic [8*`LSM_MEM_DEPTH-1:0] segment_image; // displayed bytes
    logic display_on, pump_on, ladder_on, comp_en, auto_blink; // status outputs
    logic [5:0] bias_level; // bias level
    logic [2:0] blink_rate; // blink rate index
    logic [28:0][3:0] seg_lit; // glass view
    logic [119:0] exp_img; // expected image after the update
    int fail_count = 0; // mismatches
    int checks_done = 0; // comparisons
    int cycles = 0; // timeout counter

    lsm_top u_dut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .rtc_enabled(rtc_enabled), .battery_sleep_state(battery_sleep_state),
        .sfr_rdata(sfr_rdata), .segment_image(segment_image), .display_on(display_on), .pump_on(pump_on),
        .ladder_on(ladder_on), .comp_en(comp_en), .bias_level(bias_level), .auto_blink(auto_blink),
        .blink_rate(blink_rate));
    lsm_glass u_glass (.segment_image(segment_image), .display_on(display_on), .seg_lit(seg_lit));

    // 200 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // compare and count
    task automatic chk(input logic [119:0] seen, input logic [119:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one register write, strobe for one cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_wr <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
    endtask

    // register read, data valid one edge after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        sfr_addr <= a;
        @(posedge clk_sys);
        #1 d = sfr_rdata;
    endtask

    // let registered outputs settle
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // test pattern per memory byte
    function automatic logic [7:0] pat(input int i);
        return 8'(8'h11 * (i + 1));
    endfunction

    // all registers and the image clear after reset, unmapped reads zero
    task automatic t_reset;
        logic [7:0] d;
        logic [7:0] regs [7];
        regs = '{`LSM_OFS_MAIN_CONFIG, `LSM_OFS_CLOCK_SELECT, `LSM_OFS_VOLTAGE_CONFIG, `LSM_OFS_MEM_POINTER,
            `LSM_OFS_MEM_DATA, `LSM_OFS_UPDATE_CONTROL, 8'h00};
        foreach (regs[i]) begin
            rd(regs[i], d);
            chk(d, 0);
        end
        chk(segment_image, 0);
        chk(ladder_on, 0);
    endtask

    // frozen update of all bytes, out-of-range access, read back
    task automatic t_mem;
        logic [7:0] d;
        wr(`LSM_OFS_MAIN_CONFIG, 8'h80);
        wr(`LSM_OFS_UPDATE_CONTROL, 8'h01);
        for (int i = 0; i < 15; i++) begin
            wr(`LSM_OFS_MEM_DATA, pat(i));
            wr(`LSM_OFS_MEM_POINTER, 8'h80 | 8'(i));
            exp_img[8*i +: 8] = (i == 14) ? 8'h0f : pat(i);
        end
        wr(`LSM_OFS_MEM_POINTER, 8'hcf);
        tick(2);
        chk(segment_image, 0);
        rd(`LSM_OFS_MEM_POINTER, d);
        chk(d, 8'h8f);
        wr(`LSM_OFS_UPDATE_CONTROL, 8'h00);
        tick(2);
        chk(segment_image, exp_img);
        for (int n = 0; n < 29; n++) begin
            chk(seg_lit[n], exp_img[8*(n/2)+4*(n%2) +: 4]);
        end
        for (int i = 0; i < 16; i++) begin
            wr(`LSM_OFS_MEM_POINTER, 8'(i));
            rd(`LSM_OFS_MEM_DATA, d);
            chk(d, (i < 15) ? exp_img[8*i +: 8] : 8'h00);
        end
    endtask

    // every blink mode and frequency, with and without the clock
    task automatic t_blink;
        logic ea;
        logic [2:0] er;
        for (int m = 0; m < 4; m++) begin
            for (int f = 0; f < 8; f++) begin
                @(posedge clk_sys);
                rtc_enabled <= f[2];
                wr(`LSM_OFS_CLOCK_SELECT, {m[1:0], f[1:0], 4'h5});
                tick(2);
                ea = f[2] && m[1];
                er = !ea ? 3'h0 : (m == 3) ? 3'h4 : 3'(f[1:0]);
                chk({auto_blink, blink_rate}, {ea, er});
            end
        end
    endtask

    // voltage source, pump gating and bias level
    task automatic t_volt;
        logic [7:0] d;
        logic [5:0] b;
        for (int k = 0; k < 4; k++) begin
            b = k[0] ? 6'h3f : 6'h00;
            wr(`LSM_OFS_MAIN_CONFIG, {k[0], 7'h00});
            wr(`LSM_OFS_VOLTAGE_CONFIG, {1'b0, k[1], b});
            tick(2);
            chk({display_on, pump_on, ladder_on, comp_en}, {k[0], k[0] & !k[1], k[1], !k[1]});
            chk(bias_level, b);
            rd(`LSM_OFS_VOLTAGE_CONFIG, d);
            chk(d, {1'b0, k[1], b});
        end
    endtask

    // low-power display gating, memory kept
    task automatic t_sleep;
        @(posedge clk_sys);
        battery_sleep_state <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            wr(`LSM_OFS_MAIN_CONFIG, {k[0], 1'b0, k[1], 5'h00});
            tick(2);
            chk(display_on, k[0] & !k[1]);
            chk(segment_image, exp_img);
        end
        @(posedge clk_sys);
        battery_sleep_state <= 1'b0;
    endtask

    // clear bit empties memory and reads back as zero
    task automatic t_clear;
        logic [7:0] d;
        wr(`LSM_OFS_MAIN_CONFIG, 8'hc0);
        tick(2);
        chk(segment_image, 0);
        rd(`LSM_OFS_MAIN_CONFIG, d);
        chk(d, 8'h80);
    endtask

    // low clock enable ignores writes, reset in mid-run still clears everything
    task automatic t_hold;
        logic [7:0] d;
        wr(`LSM_OFS_MEM_DATA, 8'h5a);
        wr(`LSM_OFS_MEM_POINTER, 8'h82);
        @(posedge clk_sys);
        clk_en <= 1'b0;
        wr(`LSM_OFS_VOLTAGE_CONFIG, 8'h00);
        wr(`LSM_OFS_MAIN_CONFIG, 8'h40);
        tick(2);
        chk({ladder_on, display_on, segment_image[23:16]}, {2'b11, 8'h5a});
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        clk_en <= 1'b1;
        tick(1);
        chk(segment_image, 0);
        chk({ladder_on, display_on}, 0);
        wr(`LSM_OFS_MEM_POINTER, 8'h02);
        rd(`LSM_OFS_MEM_DATA, d);
        chk(d, 8'h00);
    endtask

    // counts and verdict
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            fail_count++;
            wrap_up();
        end
    end

    // main sequence
    initial begin
        reset = 1'b1;
        clk_en = 1'b1;
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
        rtc_enabled = 1'b0;
        battery_sleep_state = 1'b0;
        exp_img = '0;
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        t_reset();
        t_mem();
        t_blink();
        t_volt();
        t_sleep();
        t_clear();
        t_hold();
        wrap_up();
    end
endmodule
